// file: src/csq_consts.vh
// constants for the charge sequencer
`ifndef CSQ_CONSTS_VH
`define CSQ_CONSTS_VH
`define CSQ_CLK_MHZ 200
`define CSQ_DEAD_NS 50
`define CSQ_DEAD_CYC 4'hA // 50 ns at 200 MHz, rounded up
`define CSQ_TICK_DIV 1000
`define CSQ_PREQ_TICKS 450
`define CSQ_FAST_TICKS 5400
`define CSQ_FULL_TICKS 5400
`define CSQ_TOP_TICKS 2700
`define CSQ_THM_SLOT 7'h40
`define CSQ_CUR_ZERO 2'h0
`define CSQ_CUR_C20 2'h1
`define CSQ_CUR_FULL 2'h2
`define CSQ_CUR_CV 2'h3
`endif

// file: src/csq_charge_sequencer.v
// charge sequencer state machine, timers, thermistor mux and gate drive
`timescale 1ns/1ps
`include "csq_consts.vh"

module csq_charge_sequencer #(
  parameter TICK_DIV = `CSQ_TICK_DIV,
  parameter PREQ_TICKS = `CSQ_PREQ_TICKS,
  parameter FAST_TICKS = `CSQ_FAST_TICKS,
  parameter FULL_TICKS = `CSQ_FULL_TICKS,
  parameter TOP_TICKS = `CSQ_TOP_TICKS
) (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_power_down_n,
  input wire i_supply_good,
  input wire i_ref_good,
  input wire i_bias_good,
  input wire i_supply_dropout,
  input wire i_pack_overvoltage,
  input wire i_pack_above_uv,
  input wire i_pack_at_reg,
  input wire i_pack_below_recharge,
  input wire i_current_low,
  input wire i_short_timer_cap,
  input wire i_long_timer_cap,
  input wire i_temp_hot_ok,
  input wire i_temp_cold_ok,
  input wire i_pwm_on,
  input wire i_inductor_zero,
  output reg o_temp_sense_hot_sel,
  output reg [1:0] o_current_mode,
  output reg o_high_gate_drive,
  output reg o_low_gate_drive,
  output wire o_fast_phase_indicator_n_o,
  output wire o_fast_phase_indicator_n_oe,
  output wire o_voltage_phase_indicator_n_o,
  output wire o_voltage_phase_indicator_n_oe,
  output wire o_fault_indicator_n_o,
  output wire o_fault_indicator_n_oe,
  output wire [7:0] o_state
);
  localparam ST_RESET = 8'h01;
  localparam ST_PREQ = 8'h02;
  localparam ST_FAST = 8'h04;
  localparam ST_FULL = 8'h08;
  localparam ST_TOP = 8'h10;
  localparam ST_DONE = 8'h20;
  localparam ST_FAULT = 8'h40;
  localparam ST_TEMP = 8'h80;
  localparam [3:0] DEAD_CYC = `CSQ_DEAD_CYC;
  localparam [6:0] THM_SLOT = `CSQ_THM_SLOT;

  reg [7:0] state_r;
  reg [7:0] state_nxt;
  reg [7:0] susp_from_r;
  reg [15:0] div1_r;
  reg [15:0] div2_r;
  reg tick1_r;
  reg tick2_r;
  reg [15:0] t1_r;
  reg [15:0] t2_r;
  reg fast_ind_r;
  reg full_ind_r;
  reg fault_ind_r;
  reg [6:0] thm_cnt_r;
  reg hot_ok_r;
  reg cold_ok_r;
  reg [3:0] dead_r;
  reg hi_want_prev_r;
  wire temp_ok;
  wire hi_want;
  wire t1_exp;
  wire t2_exp;
  wire run_t1;
  wire run_t2;
  assign temp_ok = hot_ok_r & cold_ok_r;
  assign o_state = state_r;
  assign run_t1 = (state_r == ST_PREQ) | (state_r == ST_FULL) | (state_r == ST_TOP);
  assign run_t2 = (state_r == ST_FAST);
  assign t1_exp = (state_r == ST_PREQ) ? (t1_r >= PREQ_TICKS) :
                  (state_r == ST_FULL) ? (t1_r >= FULL_TICKS) : (t1_r >= TOP_TICKS);
  assign t2_exp = (t2_r >= FAST_TICKS);

  // capacitor-paced time bases: each cap input is a ramp comparator toggle scaled by C
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      div1_r <= 16'h0000;
      div2_r <= 16'h0000;
      tick1_r <= 1'b0;
      tick2_r <= 1'b0;
    end
    else
    begin
      tick1_r <= 1'b0;
      tick2_r <= 1'b0;
      if (i_short_timer_cap)
      begin
        if (div1_r >= TICK_DIV - 1)
        begin
          div1_r <= 16'h0000;
          tick1_r <= 1'b1;
        end
        else
          div1_r <= div1_r + 16'h0001;
      end
      if (i_long_timer_cap)
      begin
        if (div2_r >= TICK_DIV - 1)
        begin
          div2_r <= 16'h0000;
          tick2_r <= 1'b1;
        end
        else
          div2_r <= div2_r + 16'h0001;
      end
    end
  end
  // thermistor hot/cold multiplex
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      thm_cnt_r <= 7'h00;
      o_temp_sense_hot_sel <= 1'b0;
      hot_ok_r <= 1'b0;
      cold_ok_r <= 1'b0;
    end
    else if (thm_cnt_r >= THM_SLOT - 7'h01)
    begin
      thm_cnt_r <= 7'h00;
      o_temp_sense_hot_sel <= ~o_temp_sense_hot_sel;
      if (o_temp_sense_hot_sel)
        hot_ok_r <= i_temp_hot_ok;
      else
        cold_ok_r <= i_temp_cold_ok;
    end
    else
      thm_cnt_r <= thm_cnt_r + 7'h01;
  end

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RESET:
        if (i_supply_good & i_ref_good & i_bias_good & ~i_supply_dropout)
          state_nxt = ST_PREQ;
      ST_PREQ:
        if (!temp_ok)
          state_nxt = ST_TEMP;
        else if (i_pack_above_uv)
          state_nxt = ST_FAST;
        else if (t1_exp)
          state_nxt = ST_FAULT;
      ST_FAST:
        if (!temp_ok)
          state_nxt = ST_TEMP;
        else if (i_pack_at_reg)
          state_nxt = ST_FULL;
        else if (t2_exp)
          state_nxt = ST_FAULT;
      ST_FULL:
        if (!temp_ok)
          state_nxt = ST_TEMP;
        else if (t1_exp | i_current_low)
          state_nxt = ST_TOP;
      ST_TOP:
        if (!temp_ok)
          state_nxt = ST_TEMP;
        else if (t1_exp)
          state_nxt = ST_DONE;
      ST_DONE:
        if (i_pack_below_recharge)
          state_nxt = ST_RESET;
      ST_FAULT:
        state_nxt = ST_FAULT;
      ST_TEMP:
        if (temp_ok)
          state_nxt = susp_from_r;
      default:
        state_nxt = ST_RESET;
    endcase
    if ((i_supply_dropout | i_pack_overvoltage) & (state_r != ST_FAULT))
      state_nxt = ST_RESET;
  end
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= ST_RESET;
      susp_from_r <= ST_RESET;
      t1_r <= 16'h0000;
      t2_r <= 16'h0000;
      fast_ind_r <= 1'b1;
      full_ind_r <= 1'b1;
      fault_ind_r <= 1'b1;
    end
    else if (!i_power_down_n)
    begin
      state_r <= ST_RESET;
      t1_r <= 16'h0000;
      t2_r <= 16'h0000;
      fast_ind_r <= 1'b1;
      full_ind_r <= 1'b1;
      fault_ind_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_nxt == ST_TEMP && state_r != ST_TEMP)
        susp_from_r <= state_r;
      if (state_nxt == ST_RESET)
      begin
        t1_r <= 16'h0000;
        t2_r <= 16'h0000;
      end
      else if (state_nxt != state_r && state_r != ST_TEMP && state_nxt != ST_TEMP)
        t1_r <= 16'h0000;
      else if (run_t1 && tick1_r && t1_r != 16'hFFFF)
        t1_r <= t1_r + 16'h0001;
      if (run_t2 && tick2_r && t2_r != 16'hFFFF)
        t2_r <= t2_r + 16'h0001;
      case (state_nxt)
        ST_PREQ, ST_FAST:
        begin
          fast_ind_r <= 1'b0;
          full_ind_r <= 1'b1;
          fault_ind_r <= 1'b1;
        end
        ST_FULL:
        begin
          fast_ind_r <= 1'b1;
          full_ind_r <= 1'b0;
          fault_ind_r <= 1'b1;
        end
        ST_FAULT:
        begin
          fast_ind_r <= 1'b1;
          full_ind_r <= 1'b1;
          fault_ind_r <= 1'b0;
        end
        ST_TEMP: fast_ind_r <= fast_ind_r;
        default:
        begin
          fast_ind_r <= 1'b1;
          full_ind_r <= 1'b1;
          fault_ind_r <= 1'b1;
        end
      endcase
    end
  end
  // current command to the analog loop
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_current_mode <= `CSQ_CUR_ZERO;
    else if (!i_power_down_n)
      o_current_mode <= `CSQ_CUR_ZERO;
    else
    begin
      case (state_r)
        ST_PREQ: o_current_mode <= `CSQ_CUR_C20;
        ST_FAST: o_current_mode <= `CSQ_CUR_FULL;
        ST_FULL, ST_TOP: o_current_mode <= `CSQ_CUR_CV;
        default: o_current_mode <= `CSQ_CUR_ZERO;
      endcase
    end
  end
  // gate drive with dead time
  assign hi_want = i_pwm_on & (o_current_mode != `CSQ_CUR_ZERO);
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_high_gate_drive <= 1'b0;
      o_low_gate_drive <= 1'b0;
      dead_r <= 4'h0;
      hi_want_prev_r <= 1'b0;
    end
    else if (!i_power_down_n)
    begin
      o_high_gate_drive <= 1'b0;
      o_low_gate_drive <= 1'b0;
      dead_r <= DEAD_CYC;
      hi_want_prev_r <= 1'b0;
    end
    else
    begin
      hi_want_prev_r <= hi_want;
      if (hi_want != hi_want_prev_r)
      begin
        o_high_gate_drive <= 1'b0;
        o_low_gate_drive <= 1'b0;
        dead_r <= DEAD_CYC;
      end
      else if (dead_r != 4'h0)
        dead_r <= dead_r - 4'h1;
      else
      begin
        o_high_gate_drive <= hi_want;
        o_low_gate_drive <= ~hi_want & (o_current_mode != `CSQ_CUR_ZERO) & ~i_inductor_zero;
      end
    end
  end

  // open-drain indicators: drive low only when active
  assign o_fast_phase_indicator_n_o = 1'b0;
  assign o_voltage_phase_indicator_n_o = 1'b0;
  assign o_fault_indicator_n_o = 1'b0;
  assign o_fast_phase_indicator_n_oe = i_power_down_n & ~fast_ind_r;
  assign o_voltage_phase_indicator_n_oe = i_power_down_n & ~full_ind_r;
  assign o_fault_indicator_n_oe = i_power_down_n & ~fault_ind_r;
endmodule // csq_charge_sequencer

// file: verification/csq_pack_model.sv
// pack side model: thermistor comparators and timer capacitor pacing
`timescale 1ns/1ps
module csq_pack_model (
  input wire logic i_clock,
  input wire logic i_hot_sel,
  input wire logic i_in_range,
  output logic o_hot_ok,
  output logic o_cold_ok,
  output logic o_short_pulse,
  output logic o_long_pulse
);
  logic [2:0] cnt_r = 3'h0;
  always @(posedge i_clock)
  begin
    cnt_r <= #1 cnt_r + 3'h1;
  end
  assign o_short_pulse = (cnt_r == 3'h0);
  assign o_long_pulse = (cnt_r == 3'h4);
  // unselected comparator shows the wrong answer
  assign o_hot_ok = i_hot_sel ? i_in_range : ~i_in_range;
  assign o_cold_ok = i_hot_sel ? ~i_in_range : i_in_range;
endmodule // csq_pack_model

// file: verification/csq_charge_sequencer_asserts.sv
// checker for the charge sequencer ports
`timescale 1ns/1ps
module csq_charge_sequencer_asserts (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_power_down_n,
  input wire i_supply_dropout,
  input wire i_inductor_zero,
  input wire o_high_gate_drive,
  input wire o_low_gate_drive,
  input wire o_fast_phase_indicator_n_oe,
  input wire o_voltage_phase_indicator_n_oe,
  input wire o_fault_indicator_n_oe,
  input wire [7:0] o_state
);
  wire [2:0] leds = {o_fast_phase_indicator_n_oe, o_voltage_phase_indicator_n_oe, o_fault_indicator_n_oe};
  wire hi = o_high_gate_drive;
  wire lo = o_low_gate_drive;
  wire on = i_power_down_n;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  chk_reset_leds_off: assert property (o_state == 8'h01 |-> leds == 3'h0) else $error("led on in reset");
  chk_dropout_resets: assert property (i_supply_dropout && o_state != 8'h40 |=> o_state == 8'h01)
    else $error("no reset on dropout");
  chk_prequal_leds: assert property (on && o_state == 8'h02 |-> leds == 3'h4) else $error("prequal leds");
  chk_full_leds: assert property (on && o_state == 8'h08 |-> leds == 3'h2) else $error("full leds");
  chk_fault_leds: assert property (on && o_state == 8'h40 |-> leds == 3'h1) else $error("fault leds");
  chk_fault_held: assert property (on && o_state == 8'h40 |=> o_state == 8'h40) else $error("fault left");
  chk_shutdown_off: assert property (!on |-> (leds == 3'h0) ##1 (!hi && !lo)) else $error("shutdown drive");
  chk_dead_time: assert property ($fell(hi) |-> !lo [*8]) else $error("dead time short");
  chk_no_overlap: assert property ($fell(lo) |-> !hi [*8]) else $error("gates overlap");
  chk_zero_cut: assert property (i_inductor_zero |=> !lo) else $error("low gate on at zero");
endmodule // csq_charge_sequencer_asserts
bind csq_charge_sequencer csq_charge_sequencer_asserts i_chk (
  .i_clock(i_clock),
  .i_rst_n(i_rst_n),
  .i_power_down_n(i_power_down_n),
  .i_supply_dropout(i_supply_dropout),
  .i_inductor_zero(i_inductor_zero),
  .o_high_gate_drive(o_high_gate_drive),
  .o_low_gate_drive(o_low_gate_drive),
  .o_fast_phase_indicator_n_oe(o_fast_phase_indicator_n_oe),
  .o_voltage_phase_indicator_n_oe(o_voltage_phase_indicator_n_oe),
  .o_fault_indicator_n_oe(o_fault_indicator_n_oe),
  .o_state(o_state)
);

// file: verification/csq_charge_sequencer_tb_top.sv
// self-checking bench for the charge sequencer
`timescale 1ns/1ps
module csq_charge_sequencer_tb_top;
  logic i_clock = 1'h0, i_rst_n = 1'h0, i_power_down_n = 1'h1, i_supply_good = 1'h0, i_ref_good = 1'h0;
  logic i_bias_good = 1'h0, i_supply_dropout = 1'h0, i_pack_overvoltage = 1'h0, i_pack_above_uv = 1'h0;
  logic i_pack_at_reg = 1'h0, i_pack_below_recharge = 1'h0, i_current_low = 1'h0, i_pwm_on = 1'h0;
  logic i_inductor_zero = 1'h0, in_range = 1'h1;
  wire i_temp_hot_ok, i_temp_cold_ok, i_short_timer_cap, i_long_timer_cap, o_temp_sense_hot_sel;
  wire o_high_gate_drive, o_low_gate_drive, o_fast_phase_indicator_n_o, o_fast_phase_indicator_n_oe;
  wire o_voltage_phase_indicator_n_o, o_voltage_phase_indicator_n_oe, o_fault_indicator_n_o, o_fault_indicator_n_oe;
  wire [1:0] o_current_mode;
  wire [7:0] o_state;
  wire [2:0] leds_oe = {o_fast_phase_indicator_n_oe, o_voltage_phase_indicator_n_oe, o_fault_indicator_n_oe};
  wire [2:0] leds_o = {o_fast_phase_indicator_n_o, o_voltage_phase_indicator_n_o, o_fault_indicator_n_o};
  logic hot_prev;
  int num_errors = 0, compares = 0;
  always #2.5 i_clock = ~i_clock;
  csq_charge_sequencer #(.TICK_DIV(2), .PREQ_TICKS(4), .FAST_TICKS(8), .FULL_TICKS(8), .TOP_TICKS(6)) i_dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_power_down_n(i_power_down_n), .i_supply_good(i_supply_good),
    .i_ref_good(i_ref_good), .i_bias_good(i_bias_good), .i_supply_dropout(i_supply_dropout),
    .i_pack_overvoltage(i_pack_overvoltage), .i_pack_above_uv(i_pack_above_uv), .i_pack_at_reg(i_pack_at_reg),
    .i_pack_below_recharge(i_pack_below_recharge), .i_current_low(i_current_low),
    .i_short_timer_cap(i_short_timer_cap), .i_long_timer_cap(i_long_timer_cap), .i_temp_hot_ok(i_temp_hot_ok),
    .i_temp_cold_ok(i_temp_cold_ok), .i_pwm_on(i_pwm_on), .i_inductor_zero(i_inductor_zero),
    .o_temp_sense_hot_sel(o_temp_sense_hot_sel), .o_current_mode(o_current_mode),
    .o_high_gate_drive(o_high_gate_drive), .o_low_gate_drive(o_low_gate_drive),
    .o_fast_phase_indicator_n_o(o_fast_phase_indicator_n_o),
    .o_fast_phase_indicator_n_oe(o_fast_phase_indicator_n_oe),
    .o_voltage_phase_indicator_n_o(o_voltage_phase_indicator_n_o),
    .o_voltage_phase_indicator_n_oe(o_voltage_phase_indicator_n_oe),
    .o_fault_indicator_n_o(o_fault_indicator_n_o),
    .o_fault_indicator_n_oe(o_fault_indicator_n_oe),
    .o_state(o_state));
  csq_pack_model i_pack (.i_clock(i_clock), .i_hot_sel(o_temp_sense_hot_sel), .i_in_range(in_range),
    .o_hot_ok(i_temp_hot_ok), .o_cold_ok(i_temp_cold_ok), .o_short_pulse(i_short_timer_cap),
    .o_long_pulse(i_long_timer_cap));
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // current level expected for each state
  function automatic logic [1:0] model_mode(input logic [7:0] s);
    case (s)
      8'h02: return 2'h1;
      8'h04: return 2'h2;
      8'h08, 8'h10: return 2'h3;
      default: return 2'h0;
    endcase
  endfunction
  // active indicators {fast, voltage, fault} expected for each state
  function automatic logic [2:0] model_leds(input logic [7:0] s);
    case (s)
      8'h02, 8'h04: return 3'h4;
      8'h08: return 3'h2;
      8'h40: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction
  task automatic step(input logic [7:0] exp);
    int n;
    n = 0;
    while (o_state !== exp && n < 3000)
    begin
      tick(1);
      n++;
    end
    chk(o_state, exp);
    if (exp != 8'h80)
      chk({5'h00, leds_oe}, {5'h00, model_leds(exp)});
    chk({5'h00, leds_o}, 8'h00);
    tick(1);
    chk({6'h00, o_current_mode}, {6'h00, model_mode(exp)});
  endtask
  task automatic results;
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge i_clock)
  begin
    #1;
    if ($urandom % 40 == 0)
      i_pwm_on = ~i_pwm_on;
    i_inductor_zero = ($urandom % 16 == 0);
  end
  initial
  begin
    #50000;
    num_errors++;
    results();
  end
  initial
  begin
    void'($urandom(32'h0bdf));
    {i_supply_good, i_ref_good, i_bias_good} = 3'($urandom % 7);
    tick(20);
    i_rst_n = 1'h1;
    tick(10);
    hot_prev = o_temp_sense_hot_sel;
    tick(64);
    chk(o_temp_sense_hot_sel, !hot_prev);
    chk(o_state, 8'h01);
    {i_supply_good, i_ref_good, i_bias_good} = 3'h7;
    step(8'h02);
    step(8'h40);
    i_supply_dropout = 1'h1;
    tick(4);
    chk(o_state, 8'h40);
    i_supply_dropout = 1'h0;
    i_power_down_n = 1'h0;
    tick(4);
    chk(o_state, 8'h01);
    chk({5'h00, o_fast_phase_indicator_n_oe, o_voltage_phase_indicator_n_oe, o_fault_indicator_n_oe}, 8'h00);
    i_power_down_n = 1'h1;
    step(8'h02);
    i_pack_above_uv = 1'h1;
    step(8'h04);
    in_range = 1'h0;
    step(8'h80);
    tick(1 + $urandom % 50);
    in_range = 1'h1;
    step(8'h04);
    i_pack_at_reg = 1'h1;
    step(8'h08);
    i_current_low = 1'h1;
    step(8'h10);
    step(8'h20);
    {i_pack_above_uv, i_pack_at_reg, i_current_low, i_pack_below_recharge} = 4'h1;
    step(8'h02);
    {i_pack_above_uv, i_pack_below_recharge} = 2'h2;
    step(8'h04);
    step(8'h40);
    i_power_down_n = 1'h0;
    tick(3);
    i_power_down_n = 1'h1;
    step(8'h04);
    i_supply_dropout = 1'h1;
    step(8'h01);
    i_supply_dropout = 1'h0;
    step(8'h04);
    i_pack_overvoltage = 1'h1;
    step(8'h01);
    i_pack_overvoltage = 1'h0;
    i_pack_at_reg = 1'h1;
    step(8'h08);
    step(8'h10);
    results();
  end
endmodule // csq_charge_sequencer_tb_top
